// File: include/irq_status_defines.vh
// Offsets, bit positions and masks of the interrupt status word
`ifndef IRQ_STATUS_DEFINES_VH
`define IRQ_STATUS_DEFINES_VH
`define STATUS_OFFSET     12'h058
`define ENABLE_OFFSET     12'h05c
`define BIT_SOFTWARE      31
`define BIT_READY         30
`define BIT_TIMESTAMP     29
`define BIT_SWITCH        28
`define BIT_PHY2          27
`define BIT_PHY1          26
`define BIT_TX_HALT       25
`define BIT_RX_HALT       24
`define BIT_DROP_MID      23
`define BIT_BUF_DONE      21
`define BIT_DMA_DONE      20
`define BIT_TIMER_WRAP    19
`define BIT_POWER         17
`define BIT_TXS_OVF       16
`define BIT_OVERSIZE      15
`define LATCH_MASK        32'hc3bb8000
`define LEVEL_MASK        32'h3c000000
`define OWNED_MASK        32'hffff8000
`define STATUS_RESET      32'h00000000
`define ENABLE_RESET      32'h00000000
`endif

// File: hdl/interrupt_status_aggregator.v
// Top-level interrupt status word (bits 31..15) with its enable word on APB
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_defines.vh"
module interrupt_status_aggregator #(
   parameter ADDR_WIDTH = 12
) (
   input  wire                  mclk,
   input  wire                  nrst,
   input  wire                  clkEn,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire [31:0]           pwdata,
   input  wire [3:0]            pstrb,
   output reg  [31:0]           prdata,
   output wire                  pready,
   output wire                  pslverr,
   input  wire                  deviceReady,
   input  wire                  timestampUnitEvent,
   input  wire                  switchEvent,
   input  wire                  secondPhyEvent,
   input  wire                  firstPhyEvent,
   input  wire                  txStopRequest,
   input  wire                  txHalted,
   input  wire                  rxHalted,
   input  wire                  dropCounterMsb,
   input  wire                  bufferCompletePulse,
   input  wire                  dmaCountDonePulse,
   input  wire                  timerWrapPulse,
   input  wire                  powerEventPulse,
   input  wire                  powerControlPending,
   input  wire                  txStatusOverflowPulse,
   input  wire                  oversizeRxPulse,
   output wire [31:0]           statusWord,
   output wire [31:0]           enableWord,
   output wire                  masterIrq,
   output wire                  powerIrq
);

   // Register addresses and bit groups, sized to the buses they meet
   localparam [ADDR_WIDTH-1:0] STATUS_ADDR = `STATUS_OFFSET;
   localparam [ADDR_WIDTH-1:0] ENABLE_ADDR = `ENABLE_OFFSET;
   localparam [31:0]           LATCH_BITS  = `LATCH_MASK;
   localparam [31:0]           LEVEL_BITS  = `LEVEL_MASK;
   localparam [31:0]           OWNED_BITS  = `OWNED_MASK;
   localparam [31:0]           STATUS_INIT = `STATUS_RESET;
   localparam [31:0]           ENABLE_INIT = `ENABLE_RESET;

   // Bus decode
   wire                        busSetup;
   wire                        busAccess;
   wire                        hitStatus;
   wire                        hitEnable;
   wire                        statusWrite;
   wire                        enableWrite;
   wire                        readSetup;
   wire [31:0]                 laneMask;
   wire [31:0]                 writeOnes;

   // Event detection
   wire                        readyRise;
   wire                        dropRise;
   wire                        txStopped;
   wire                        powerAckOk;
   wire [31:0]                 levelVec;
   reg  [31:0]                 setVec;
   reg  [31:0]                 ackVec;

   // State and next-state values
   wire [31:0]                 status_next;
   reg  [31:0]                 status_reg;
   reg  [31:0]                 enable_reg;
   reg  [31:0]                 enable_next;
   reg                         dropMsb_reg;
   reg                         dropMsb_next;
   reg                         readySeen_reg;
   reg                         readySeen_next;
   reg  [31:0]                 prdata_next;

   // Sources are assumed synchronous to mclk, so no synchronisers sit on them
   // Every access completes with no wait states and no error
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   assign busSetup    = psel & ~penable & clkEn;
   assign busAccess   = psel & penable & clkEn;
   assign hitStatus   = (paddr == STATUS_ADDR);
   assign hitEnable   = (paddr == ENABLE_ADDR);
   assign statusWrite = busAccess & pwrite & hitStatus;
   assign enableWrite = busAccess & pwrite & hitEnable;
   assign readSetup   = busSetup & ~pwrite;

   // Byte strobes gate which lanes a write may touch
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
         assign laneMask[lane*8 +: 8] = {8{pstrb[lane]}};
      end
   endgenerate

   assign writeOnes = statusWrite ? (pwdata & laneMask) : 32'h00000000;

   // Ready flags once per reset, not every cycle the device stays ready
   assign readyRise  = deviceReady & ~readySeen_reg;
   // Only the zero-to-one step of the counter's top bit counts as the midpoint
   assign dropRise   = dropCounterMsb & ~dropMsb_reg;
   // A halt without a stop request is not reported
   assign txStopped  = txStopRequest & txHalted;
   // Power flag refuses the acknowledge while control bits are still pending
   assign powerAckOk = ~powerControlPending;

   // Mirrored sources: pending events owned elsewhere, shown live
   assign levelVec = ({31'h0, timestampUnitEvent} << `BIT_TIMESTAMP)
                   | ({31'h0, switchEvent} << `BIT_SWITCH)
                   | ({31'h0, secondPhyEvent} << `BIT_PHY2)
                   | ({31'h0, firstPhyEvent} << `BIT_PHY1);

   always @* begin
      setVec                  = 32'h00000000;
      setVec[`BIT_SOFTWARE]   = enable_reg[`BIT_SOFTWARE];
      setVec[`BIT_READY]      = readyRise;
      setVec[`BIT_TX_HALT]    = txStopped;
      setVec[`BIT_RX_HALT]    = rxHalted;
      setVec[`BIT_DROP_MID]   = dropRise;
      setVec[`BIT_BUF_DONE]   = bufferCompletePulse;
      setVec[`BIT_DMA_DONE]   = dmaCountDonePulse;
      setVec[`BIT_TIMER_WRAP] = timerWrapPulse;
      setVec[`BIT_POWER]      = powerEventPulse;
      setVec[`BIT_TXS_OVF]    = txStatusOverflowPulse;
      setVec[`BIT_OVERSIZE]   = oversizeRxPulse;
   end

   always @* begin
      // Only ones written clear; zeros and non-latched positions are ignored
      ackVec = writeOnes & LATCH_BITS;
      if (!powerAckOk) begin
         ackVec[`BIT_POWER] = 1'b0;
      end
   end

   genvar bitIdx;
   generate
      for (bitIdx = 0; bitIdx < 32; bitIdx = bitIdx + 1) begin : gStatus
         if (LEVEL_BITS[bitIdx]) begin : gLevel
            // Live copy of the source; writes have no effect
            assign status_next[bitIdx] = levelVec[bitIdx];
         end else if (LATCH_BITS[bitIdx]) begin : gLatched
            // Set beats a same-cycle acknowledge so no event is lost
            assign status_next[bitIdx] = setVec[bitIdx]
                                       | (status_reg[bitIdx] & ~ackVec[bitIdx]);
         end else begin : gReserved
            assign status_next[bitIdx] = 1'b0;
         end
      end
   endgenerate

   always @* begin
      enable_next = enable_reg;
      if (enableWrite) begin
         enable_next = (enable_reg & ~laneMask) | (pwdata & laneMask);
      end
      // Only bits 31..15 belong to this block
      enable_next = enable_next & OWNED_BITS;
   end

   always @* begin
      dropMsb_next   = dropCounterMsb;
      readySeen_next = readySeen_reg | deviceReady;
   end

   // Read data is taken at the setup edge and then stands through the access phase
   always @* begin
      prdata_next = prdata;
      if (readSetup) begin
         if (hitStatus) begin
            prdata_next = status_next & OWNED_BITS;
         end else if (hitEnable) begin
            prdata_next = enable_next;
         end else begin
            prdata_next = 32'h00000000;
         end
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         status_reg <= STATUS_INIT;
      end else if (clkEn) begin
         status_reg <= status_next;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         enable_reg <= ENABLE_INIT;
      end else if (clkEn) begin
         enable_reg <= enable_next;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dropMsb_reg <= 1'b0;
      end else if (clkEn) begin
         dropMsb_reg <= dropMsb_next;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         readySeen_reg <= 1'b0;
      end else if (clkEn) begin
         readySeen_reg <= readySeen_next;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (clkEn) begin
         prdata <= prdata_next;
      end
   end

   assign statusWord = status_reg;
   assign enableWord = enable_reg;
   // Independent of pin enable and de-assertion interval
   assign masterIrq  = |(status_reg & enable_reg & OWNED_BITS);
   // Raw power interrupt for the pin stage, never held back by the interval
   assign powerIrq   = status_reg[`BIT_POWER] & enable_reg[`BIT_POWER];

endmodule
`default_nettype wire

// File: tb/irq_status_properties.sv
// Assertions on the interrupt status aggregator ports
`timescale 1ns/1ps
`default_nettype none
module irq_status_properties (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        clkEn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        rxHalted,
   input wire logic        oversizeRxPulse,
   input wire logic        powerControlPending,
   input wire logic [31:0] statusWord,
   input wire logic [31:0] enableWord,
   input wire logic        masterIrq
);
   wire statusWr = clkEn & psel & penable & pwrite & (paddr == 12'h058);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   property p_rsvd; {statusWord[22], statusWord[18]} == 2'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_master; masterIrq == |(statusWord & enableWord); endproperty
   a_master: assert property (p_master) else $error("master line wrong");
   property p_sw; clkEn && enableWord[31] |=> statusWord[31]; endproperty
   a_sw: assert property (p_sw) else $error("software bit not set");
   property p_rx; clkEn && rxHalted |=> statusWord[24]; endproperty
   a_rx: assert property (p_rx) else $error("rx halt not latched");
   property p_hold; statusWord[24] && !(statusWr && pwdata[24] && pstrb[3]) |=> statusWord[24];
   endproperty
   a_hold: assert property (p_hold) else $error("latched bit lost");
   property p_ack; statusWr && pwdata[15] && pstrb[1] && !oversizeRxPulse |=> !statusWord[15];
   endproperty
   a_ack: assert property (p_ack) else $error("ack ignored");
   property p_over; clkEn && oversizeRxPulse |=> statusWord[15]; endproperty
   a_over: assert property (p_over) else $error("oversize not latched");
   property p_pme; powerControlPending && statusWord[17] |=> statusWord[17]; endproperty
   a_pme: assert property (p_pme) else $error("power bit cleared early");
endmodule
bind interrupt_status_aggregator irq_status_properties chk (.mclk, .nrst, .clkEn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .rxHalted, .oversizeRxPulse,
   .powerControlPending, .statusWord, .enableWord, .masterIrq);
`default_nettype wire

// File: tb/interrupt_status_aggregator_test.sv
// Bench for the interrupt status word over APB
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_aggregator_test;
   logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, stopReq = 0, pend = 0;
   logic        clkEn = 1, slverr;
   logic [3:0]  pstrb = 4'hf;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, src = '0, prdata, statusWord, enableWord, rd;
   logic        pready, masterIrq, powerIrq;
   int          errors = 0, compares = 0, lst[9] = '{25, 24, 23, 21, 20, 19, 17, 16, 15};
   always #25 mclk = ~mclk;
   interrupt_status_aggregator DUT (.mclk, .nrst, .clkEn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr(slverr), .deviceReady(src[30]),
      .timestampUnitEvent(src[29]), .switchEvent(src[28]), .secondPhyEvent(src[27]),
      .firstPhyEvent(src[26]), .txStopRequest(stopReq), .txHalted(src[25]), .rxHalted(src[24]),
      .dropCounterMsb(src[23]), .bufferCompletePulse(src[21]), .dmaCountDonePulse(src[20]),
      .timerWrapPulse(src[19]), .powerEventPulse(src[17]), .powerControlPending(pend),
      .txStatusOverflowPulse(src[16]), .oversizeRxPulse(src[15]), .statusWord, .enableWord,
      .masterIrq, .powerIrq);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic pulse(input int n);
      src[n] <= 1'b1;
      @(posedge mclk);
      src[n] <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      rdc(12'h058, 32'h0);
      src[30] <= 1'b1;
      pulse(25);
      rdc(12'h058, 32'h40000000);
      xfer(1'b1, 12'h058, 32'h40000000);
      rdc(12'h058, 32'h0);
      stopReq <= 1'b1;
      foreach (lst[i]) begin
         pulse(lst[i]);
         rdc(12'h058, 32'h1 << lst[i]);
         xfer(1'b1, 12'h058, 32'h0);
         rdc(12'h058, 32'h1 << lst[i]);
         xfer(1'b1, 12'h058, 32'h1 << lst[i]);
         rdc(12'h058, 32'h0);
      end
      clkEn <= 1'b0;
      pulse(24);
      clkEn <= 1'b1;
      rdc(12'h058, 32'h0);
      pulse(24);
      pstrb <= 4'h7;
      xfer(1'b1, 12'h058, 32'h01000000);
      rdc(12'h058, 32'h01000000);
      pstrb <= 4'hf;
      xfer(1'b1, 12'h058, 32'h01000000);
      rdc(12'h058, 32'h0);
      $display("latched sources done");
      for (int b = 26; b < 30; b++) begin
         src[b] <= 1'b1;
         xfer(1'b1, 12'h058, 32'hffffffff);
         rdc(12'h058, 32'h1 << b);
         src[b] <= 1'b0;
         rdc(12'h058, 32'h0);
      end
      $display("mirrored sources done");
      pend <= 1'b1;
      pulse(17);
      xfer(1'b1, 12'h058, 32'h00020000);
      rdc(12'h058, 32'h00020000);
      xfer(1'b1, 12'h05c, 32'h80020000);
      rdc(12'h058, 32'h80020000);
      rdc(12'h05c, 32'h80020000);
      @(negedge mclk);
      chk({masterIrq, powerIrq}, 32'h3);
      chk(enableWord, 32'h80020000);
      chk(statusWord, 32'h80020000);
      chk({31'h0, slverr}, 32'h0);
      @(posedge mclk);
      pend <= 1'b0;
      xfer(1'b1, 12'h05c, 32'h0);
      xfer(1'b1, 12'h058, 32'h80020000);
      rdc(12'h058, 32'h0);
      rdc(12'h100, 32'h0);
      $display("power and enable done");
      wrap_up();
   end
endmodule
`default_nettype wire
